// ### verilog/sfe_erase_seq.sv
/*
 * Erase, suspend/resume and deep power-down sequencer of a serial flash.
 * Assumes the serial pins come from the host asynchronously; the program
 * engine, status register and protection logic sit outside and share
 * their flags through plain ports.
 */
// Overview of operation
// - Opcode 20h plus 24-bit address erases the containing 4K sector.
// - Opcode 52h plus address erases the containing 32K block.
// - Opcode D8h plus address erases the containing 64K block.
// - Opcode C7h or 60h alone erases the whole array.
// - Erase opcodes are accepted only while the write enable latch is set.
// - Chip select must rise right after the last byte's eighth bit.
// - Valid erase starts self-timed; busy stays high until completion.
// - Completed erase clears the write enable latch.
// - Protected target skips sector/block erase; any protection skips chip erase.
// - Suspend 75h accepted only when not suspended and busy on erase/program.
// - Suspend during whole-chip erase is ignored.
// - While erase suspended, status write and all erase opcodes are refused.
// - While program suspended, status write and program opcodes are refused.
// - Accepted suspend sets suspend flag at once; busy drops within latency.
// - Power loss while suspended clears the suspend flag; resume then ignored.
// - Resume 7Ah accepted only when suspended and not busy.
// - Resume clears suspend at once, raises busy within 200ns, then completes.
// - Opcode B9h, properly terminated, enters deep power-down within latency.
// - In deep power-down only release opcode ABh is recognised.
// - Device always powers up in normal operation.
module sfe_erase_seq
	import sfe_pkg::*;
#(
	parameter int SMALL_REGION_ERASE_TIME = SMALL_REGION_ERASE_US * 250,
	parameter int HALF_BLOCK_ERASE_TIME   = HALF_BLOCK_ERASE_US * 250,
	parameter int FULL_BLOCK_ERASE_TIME   = FULL_BLOCK_ERASE_US * 250,
	parameter int WHOLE_ARRAY_ERASE_TIME  = WHOLE_ARRAY_ERASE_US * 250,
	parameter int SUSPEND_TIME            = SUSPEND_LATENCY_CYC
)(
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst,
	input  wire logic                 i_cs_n,
	input  wire logic                 i_sclk,
	input  wire logic                 i_mosi,
	input  wire logic                 i_write_enable_latch,
	input  wire logic                 i_region_protected,
	input  wire logic                 i_any_protected,
	input  wire logic                 i_program_busy,
	output logic                      o_wel_clear,
	output logic                      o_busy,
	output logic                      o_suspend_flag,
	output logic                      o_powerdown,
	output logic                      o_erase_start,
	output sfe_pkg::sfe_op_t          o_erase_kind,
	output logic [sfe_pkg::ADDR_W-1:0] o_erase_addr,
	output logic                      o_program_suspend,
	output logic                      o_refused
);
	import sfe_pkg::*;

	localparam logic [CNT_W-1:0] RESUME_CNT = CNT_W'(RESUME_BUSY_CYC);
	localparam logic [CNT_W-1:0] PD_CNT = CNT_W'(PD_ENTRY_CYC);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ERASING,
		ST_SUSPENDING,
		ST_SUSPENDED,
		ST_RESUMING,
		ST_PD_ENTRY,
		ST_POWERDOWN
	} sfe_state_t;

	typedef struct packed {
		sfe_state_t           state;
		sfe_op_t              kind;
		logic [CNT_W-1:0]     remain;
		logic [CNT_W-1:0]     wait_cnt;
		logic [ADDR_W-1:0]    addr;
		logic                 busy;
		logic                 suspend_flag;
		logic                 prog_sus;
		logic                 pd;
		logic                 wel_clear;
		logic                 start;
		logic                 refused;
	} sfe_seq_t;

	sfe_seq_t st;
	sfe_seq_t next_st;

	logic        rx_end;
	logic [5:0]  rx_bits;
	logic [31:0] rx_shift;

	// ==========================================================
	// Serial front end.
	sfe_link_rx u_rx (
		.i_clk_sys   (i_clk_sys),
		.i_rst       (i_rst),
		.i_cs_n      (i_cs_n),
		.i_sclk      (i_sclk),
		.i_mosi      (i_mosi),
		.o_frame_end (rx_end),
		.o_bits      (rx_bits),
		.o_shift     (rx_shift),
		.o_op_ready  (),
		.o_opcode    ()
	);

	// Frame opcode is the top byte of a four-byte frame, else the low byte.
	function automatic logic [7:0] frame_op(input logic [5:0] bits, input logic [31:0] sh);
		frame_op = (bits == BITS_OP_ADDR) ? sh[31:24] : sh[7:0];
	endfunction

	// First byte of a whole-byte frame of up to four bytes.
	function automatic logic [7:0] lead_byte(input logic [5:0] bits, input logic [31:0] sh);
		case (bits)
			6'h08:   lead_byte = sh[7:0];
			6'h10:   lead_byte = sh[15:8];
			6'h18:   lead_byte = sh[23:16];
			default: lead_byte = sh[31:24];
		endcase
	endfunction

	// A frame whose length is a whole number of bytes, four at the most.
	function automatic logic whole_frame(input logic [5:0] bits);
		whole_frame = bits[2:0] == 3'h0 && bits != 6'h00 && bits <= BITS_OP_ADDR;
	endfunction

	// Erase duration in cycles for each kind.
	function automatic logic [CNT_W-1:0] erase_time(input sfe_op_t k);
		case (k)
			SFE_OP_SECTOR:  erase_time = CNT_W'(SMALL_REGION_ERASE_TIME);
			SFE_OP_BLOCK32: erase_time = CNT_W'(HALF_BLOCK_ERASE_TIME);
			SFE_OP_BLOCK64: erase_time = CNT_W'(FULL_BLOCK_ERASE_TIME);
			default:        erase_time = CNT_W'(WHOLE_ARRAY_ERASE_TIME);
		endcase
	endfunction

	// Region base: bits below the region size are don't-care.
	function automatic logic [ADDR_W-1:0] region_base(input sfe_op_t k,
		input logic [ADDR_W-1:0] a);
		case (k)
			SFE_OP_SECTOR:  region_base = {a[ADDR_W-1:SECTOR_LSB], 12'h000};
			SFE_OP_BLOCK32: region_base = {a[ADDR_W-1:BLOCK32_LSB], 15'h0000};
			SFE_OP_BLOCK64: region_base = {a[ADDR_W-1:BLOCK64_LSB], 16'h0000};
			default:        region_base = '0;
		endcase
	endfunction

	logic [7:0] op;
	logic       len_addr;
	logic       len_op;
	sfe_op_t    req_kind;
	logic       busy_now;

	// ==========================================================
	// Decode the frame that chip select just closed.
	always_comb begin
		op = frame_op(rx_bits, rx_shift);
		len_addr = rx_bits == BITS_OP_ADDR;
		len_op = rx_bits == BITS_OPCODE;
		busy_now = st.busy || i_program_busy;
		req_kind = SFE_OP_NONE;
		if (len_addr && op == OP_SECTOR_ERASE) begin
			req_kind = SFE_OP_SECTOR;
		end else if (len_addr && op == OP_BLOCK32_ERASE) begin
			req_kind = SFE_OP_BLOCK32;
		end else if (len_addr && op == OP_BLOCK64_ERASE) begin
			req_kind = SFE_OP_BLOCK64;
		end else if (len_op && (op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B)) begin
			req_kind = SFE_OP_CHIP;
		end
	end

	// ==========================================================
	// Main sequencer. Counts run every cycle; long erase times are
	// parameters so a bench can shorten them.
	always_comb begin
		next_st = st;
		next_st.wel_clear = 1'b0;
		next_st.start = 1'b0;
		next_st.refused = 1'b0;
		case (st.state)
			ST_IDLE: begin
				// Only a suspended program leaves the sequencer idle with the flag set.
				if (rx_end && st.prog_sus && whole_frame(rx_bits) &&
					lead_byte(rx_bits, rx_shift) inside
					{OP_WRITE_STATUS, OP_PAGE_PROG, OP_QUAD_PROG, OP_SECREG_PROG}) begin
					next_st.refused = 1'b1;
				end else if (rx_end && !busy_now && req_kind != SFE_OP_NONE) begin
					// Unlatched or protected targets drop silently.
					if (i_write_enable_latch &&
						!(req_kind == SFE_OP_CHIP ? i_any_protected
						: i_region_protected)) begin
						next_st.state = ST_ERASING;
						next_st.kind = req_kind;
						next_st.addr = region_base(req_kind, rx_shift[ADDR_W-1:0]);
						next_st.remain = erase_time(req_kind);
						next_st.busy = 1'b1;
						next_st.start = 1'b1;
					end
				end else if (rx_end && len_op && op == OP_RESUME) begin
					if (st.suspend_flag && !busy_now) begin
						next_st.suspend_flag = 1'b0;
						next_st.prog_sus = 1'b0;
						next_st.state = ST_RESUMING;
						next_st.wait_cnt = RESUME_CNT - CNT_W'(2);
					end
				end else if (rx_end && len_op && op == OP_SUSPEND && i_program_busy &&
					!st.suspend_flag) begin
					next_st.suspend_flag = 1'b1;
					next_st.prog_sus = 1'b1;
				end else if (rx_end && len_op && op == OP_POWER_DOWN && !busy_now &&
					!st.suspend_flag) begin
					next_st.state = ST_PD_ENTRY;
					next_st.wait_cnt = PD_CNT - CNT_W'(1);
				end
			end
			ST_ERASING: begin
				if (rx_end && len_op && op == OP_SUSPEND && !st.suspend_flag &&
					st.kind != SFE_OP_CHIP) begin
					next_st.suspend_flag = 1'b1;
					next_st.state = ST_SUSPENDING;
					next_st.wait_cnt = CNT_W'(SUSPEND_TIME) - CNT_W'(1);
				end else if (st.remain <= CNT_W'(1)) begin
					next_st.state = ST_IDLE;
					next_st.busy = 1'b0;
					next_st.wel_clear = 1'b1;
					next_st.kind = SFE_OP_NONE;
				end else begin
					next_st.remain = st.remain - CNT_W'(1);
				end
			end
			ST_SUSPENDING: begin
				if (st.wait_cnt == '0) begin
					next_st.busy = 1'b0;
					next_st.state = ST_SUSPENDED;
				end else begin
					next_st.wait_cnt = st.wait_cnt - CNT_W'(1);
				end
			end
			ST_SUSPENDED: begin
				if (rx_end && len_op && op == OP_RESUME && st.suspend_flag && !busy_now) begin
					next_st.suspend_flag = 1'b0;
					next_st.state = ST_RESUMING;
					next_st.wait_cnt = RESUME_CNT - CNT_W'(2);
				end else if (rx_end && whole_frame(rx_bits)) begin
					// Every erase opcode and the status write, in any whole-byte frame of up to four bytes.
					next_st.refused = lead_byte(rx_bits, rx_shift) inside
						{OP_WRITE_STATUS, OP_SECTOR_ERASE, OP_BLOCK32_ERASE,
						OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B,
						OP_SECREG_ERASE};
				end
			end
			ST_RESUMING: begin
				// Busy returns inside 200 ns; erase resumes where it stopped.
				if (st.wait_cnt == '0) begin
					next_st.busy = st.kind != SFE_OP_NONE;
					next_st.state = st.kind != SFE_OP_NONE ? ST_ERASING : ST_IDLE;
				end else begin
					next_st.wait_cnt = st.wait_cnt - CNT_W'(1);
				end
			end
			ST_PD_ENTRY: begin
				if (st.wait_cnt == '0) begin
					next_st.pd = 1'b1;
					next_st.state = ST_POWERDOWN;
				end else begin
					next_st.wait_cnt = st.wait_cnt - CNT_W'(1);
				end
			end
			ST_POWERDOWN: begin
				// Only the release opcode is heard; status reads included go dark.
				if (rx_end && len_op && op == OP_RELEASE_PD) begin
					next_st.pd = 1'b0;
					next_st.state = ST_IDLE;
				end
			end
			default: begin
				next_st.state = ST_IDLE;
			end
		endcase
	end

	// Reset models power-up: normal mode, suspend cleared.
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st <= '{state: ST_IDLE, kind: SFE_OP_NONE, remain: '0, wait_cnt: '0,
				addr: '0, busy: 1'b0, suspend_flag: RST_SUSPEND, prog_sus: 1'b0,
				pd: RST_POWERDOWN, wel_clear: 1'b0, start: 1'b0,
				refused: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs straight from the state register.
	assign o_wel_clear = st.wel_clear;
	assign o_busy = st.busy;
	assign o_suspend_flag = st.suspend_flag;
	assign o_powerdown = st.pd;
	assign o_erase_start = st.start;
	assign o_erase_kind = st.kind;
	assign o_erase_addr = st.addr;
	assign o_program_suspend = st.prog_sus;
	assign o_refused = st.refused;

	// ==========================================================
	// Assertions.
	sequence s_resume_taken;
		st.state == ST_SUSPENDED && next_st.state == ST_RESUMING;
	endsequence

	property p_resume_busy;
		@(posedge i_clk_sys) disable iff (i_rst)
		s_resume_taken ##1 (st.kind != SFE_OP_NONE) |-> ##[1:49] o_busy;
	endproperty
	a_resume_busy: assert property (p_resume_busy) else $error("busy late after resume");

	property p_resume_sus;
		@(posedge i_clk_sys) disable iff (i_rst)
		s_resume_taken |=> !o_suspend_flag;
	endproperty
	a_resume_sus: assert property (p_resume_sus) else $error("suspend not cleared");

	property p_suspend_set;
		@(posedge i_clk_sys) disable iff (i_rst)
		(st.state == ST_ERASING && next_st.state == ST_SUSPENDING) |=> o_suspend_flag && o_busy;
	endproperty
	a_suspend_set: assert property (p_suspend_set) else $error("suspend flag late");

	property p_chip_no_suspend;
		@(posedge i_clk_sys) disable iff (i_rst)
		(st.state == ST_ERASING && st.kind == SFE_OP_CHIP && !o_suspend_flag) |=>
			!o_suspend_flag;
	endproperty
	a_chip_no_suspend: assert property (p_chip_no_suspend) else $error("chip erase suspended");

	property p_done_wel;
		@(posedge i_clk_sys) disable iff (i_rst)
		(o_busy && st.state == ST_ERASING && next_st.state == ST_IDLE) |=> o_wel_clear && !o_busy;
	endproperty
	a_done_wel: assert property (p_done_wel) else $error("latch not cleared at end");

	property p_start_needs_wel;
		@(posedge i_clk_sys) disable iff (i_rst)
		next_st.start |-> i_write_enable_latch;
	endproperty
	a_start_needs_wel: assert property (p_start_needs_wel) else $error("erase without latch");

	property p_start_busy;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_erase_start |-> o_busy && !o_powerdown && (!o_suspend_flag || o_program_suspend);
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("erase start without busy");

	property p_pd_quiet;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_powerdown |-> !o_busy && !o_erase_start;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("activity in power-down");

	property p_region_aligned;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_erase_start |-> o_erase_addr[SECTOR_LSB-1:0] == '0;
	endproperty
	a_region_aligned: assert property (p_region_aligned) else $error("region not aligned");
endmodule

// ### verilog/sfe_pkg.sv
/*
 * Constants for the serial flash erase, suspend and power-down sequencer:
 * opcodes, array geometry, flag reset values and timing counts.
 * Assumes a 250 MHz system clock that oversamples the serial link.
 */
package sfe_pkg;
	// ==========================================================
	// Clock and timing.
	localparam int CLK_PERIOD_NS = 4;
	localparam int RESUME_BUSY_NS = 200;
	localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_PERIOD_NS;
	localparam int SUSPEND_LATENCY_US = 20;
	localparam int SUSPEND_LATENCY_CYC = SUSPEND_LATENCY_US * 1000 / CLK_PERIOD_NS;
	localparam int PD_ENTRY_US = 3;
	localparam int PD_ENTRY_CYC = PD_ENTRY_US * 1000 / CLK_PERIOD_NS;
	localparam int RELEASE_US = 3;
	localparam int RELEASE_CYC = RELEASE_US * 1000 / CLK_PERIOD_NS;
	// Erase times in microseconds; defaults of top-level parameters.
	localparam int SMALL_REGION_ERASE_US = 45000;
	localparam int HALF_BLOCK_ERASE_US = 120000;
	localparam int FULL_BLOCK_ERASE_US = 150000;
	localparam int WHOLE_ARRAY_ERASE_US = 5000000;
	localparam int CNT_W = 32;

	// ==========================================================
	// Opcodes.
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_SECREG_ERASE = 8'h44;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OP_RELEASE_PD = 8'hab;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_SECREG_PROG = 8'h42;

	// ==========================================================
	// Geometry: address bit where each region starts.
	localparam int ADDR_W = 24;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK32_LSB = 15;
	localparam int BLOCK64_LSB = 16;
	localparam int BIT_CNT_W = 6;
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_OP_ADDR = 6'h20;

	// ==========================================================
	// Reset values and kinds of operation.
	localparam logic RST_SUSPEND = 1'b0;
	localparam logic RST_POWERDOWN = 1'b0;
	typedef enum logic [2:0] {
		SFE_OP_NONE,
		SFE_OP_SECTOR,
		SFE_OP_BLOCK32,
		SFE_OP_BLOCK64,
		SFE_OP_CHIP,
		SFE_OP_PROGRAM
	} sfe_op_t;
endpackage

// ### verilog/sfe_link_rx.sv
/*
 * Serial receiver: samples chip select and serial clock through two-flop
 * synchronisers, shifts data in MSB first on rising clock edges, and
 * reports each frame at the chip select rising edge.
 * Assumes the serial clock is well below a quarter of the system clock.
 */
module sfe_link_rx
	import sfe_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic        i_mosi,
	output logic             o_frame_end,
	output logic [5:0]       o_bits,
	output logic [31:0]      o_shift,
	output logic             o_op_ready,
	output logic [7:0]       o_opcode
);
	import sfe_pkg::*;

	typedef struct packed {
		logic [1:0]  cs_s;
		logic [1:0]  ck_s;
		logic [1:0]  di_s;
		logic        ck_d;
		logic        cs_d;
		logic [5:0]  bits;
		logic [31:0] shift;
		logic        frame_end;
		logic        op_ready;
	} sfe_rx_t;

	sfe_rx_t st;
	sfe_rx_t next_st;

	// ==========================================================
	// Synchronise pins, then find edges only on the second stage.
	always_comb begin
		next_st = st;
		next_st.cs_s = {st.cs_s[0], i_cs_n};
		next_st.ck_s = {st.ck_s[0], i_sclk};
		next_st.di_s = {st.di_s[0], i_mosi};
		next_st.ck_d = st.ck_s[1];
		next_st.cs_d = st.cs_s[1];
		next_st.frame_end = 1'b0;
		next_st.op_ready = 1'b0;
		if (st.cs_s[1]) begin
			// Idle: the count restarts only after the frame-end cycle, so the
			// decoder still sees the length of the frame that just closed.
			if (st.cs_d) begin
				next_st.bits = '0;
			end
		end else if (st.ck_s[1] && !st.ck_d) begin
			next_st.shift = {st.shift[30:0], st.di_s[1]};
			if (st.bits != 6'h3f) begin
				next_st.bits = st.bits + 6'h01;
			end
			next_st.op_ready = (st.bits + 6'h01) == BITS_OPCODE;
		end
		if (st.cs_s[1] && !st.cs_d) begin
			next_st.frame_end = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st <= '{cs_s: 2'h3, ck_s: 2'h0, di_s: 2'h0, ck_d: 1'b0, cs_d: 1'b1,
				bits: 6'h00, shift: 32'h0, frame_end: 1'b0, op_ready: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Bit count is held through the frame-end pulse for the decoder.
	assign o_frame_end = st.frame_end;
	assign o_bits = st.bits;
	assign o_shift = st.shift;
	assign o_op_ready = st.op_ready;
	assign o_opcode = st.shift[7:0];
endmodule

// ### bench/sfe_host_model.sv
/*
 * Host side of the serial link: drives chip select, serial clock and data.
 * Assumes mode 0 with the clock idle low and a 125 ns clock period.
 */
module sfe_host_model (
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_mosi
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle levels; the clock stands still between frames.
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b1;
	end

	// ==========================================================
	// Frames.
	// Data changes only while the clock is low, so every rising edge sees settled data.
	task automatic frame(input logic [31:0] w, input int n);
		o_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_mosi = w[31 - i];
			#62.5 o_sclk = 1'b1;
			#62.5 o_sclk = 1'b0;
		end
		#62.5 o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
		#62.5;
	endtask

	// Whole units only: an opcode alone, or an opcode with its address.
	task automatic send_op(input logic [7:0] op);
		frame({op, 24'h000000}, 8);
	endtask

	task automatic send_cmd(input logic [31:0] w);
		frame(w, 32);
	endtask
endmodule

// ### bench/serial_flash_erase_suspend_powerdown_tb_top.sv
/*
 * Self-checking bench of the erase, suspend and power-down sequencer.
 * Assumes the host model on the link and shortened erase times.
 */
module serial_flash_erase_suspend_powerdown_tb_top
	import sfe_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Signals and settings.
	localparam int T_SUS = 20;
	localparam int TIMES [5] = '{2000, 2500, 3000, 3500, 3500};
	localparam int LSBS [5] = '{SECTOR_LSB, BLOCK32_LSB, BLOCK64_LSB, 0, 0};
	localparam logic [7:0] OPS [5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE,
		OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
	localparam sfe_op_t KINDS [5] = '{SFE_OP_SECTOR, SFE_OP_BLOCK32,
		SFE_OP_BLOCK64, SFE_OP_CHIP, SFE_OP_CHIP};
	logic        clk, rst, write_enable_latch, rprot, aprot, pbusy;
	logic        cs_n, sclk, mosi;
	logic        wclr, busy, susp, pd, start, psus, refused;
	logic [2:0]  obs;
	sfe_op_t     kind;
	logic [23:0] addr, a;
	int          failures, checks, clears, refuses, c0;
	sfe_op_t     exp_q [$];

	assign obs = {pd, susp, busy};

	// The clock toggles every half period.
	always #2 clk = ~clk;

	sfe_host_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));

	sfe_erase_seq #(
		.SMALL_REGION_ERASE_TIME(TIMES[0]),
		.HALF_BLOCK_ERASE_TIME  (TIMES[1]),
		.FULL_BLOCK_ERASE_TIME  (TIMES[2]),
		.WHOLE_ARRAY_ERASE_TIME (TIMES[3]),
		.SUSPEND_TIME           (T_SUS)
	) dut (
		.i_clk_sys(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
		.i_write_enable_latch(write_enable_latch), .i_region_protected(rprot),
		.i_any_protected(aprot), .i_program_busy(pbusy), .o_wel_clear(wclr),
		.o_busy(busy), .o_suspend_flag(susp), .o_powerdown(pd), .o_erase_start(start),
		.o_erase_kind(kind), .o_erase_addr(addr), .o_program_suspend(psus),
		.o_refused(refused)
	);

	// ==========================================================
	// Compare, wait and drive helpers.
	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({23'h0, got}, {23'h0, exp});
	endtask

	// Bounded wait on one flag; the caller compares afterwards.
	task automatic wait_for(input int idx, input logic v, input int lim);
		int n;
		n = 0;
		while (obs[idx] !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic set_in(input logic w, input logic r, input logic ap, input logic pb);
		@(negedge clk);
		write_enable_latch = w;
		rprot = r;
		aprot = ap;
		pbusy = pb;
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Pulse counters and the erase model: every start must match a queued command,
	// so a refused command that still starts is caught here.
	always @(posedge clk) begin
		if (wclr) clears++;
		if (refused) refuses++;
		if (start) begin
			if (exp_q.size() == 0) chk_bit(1'b1, 1'b0);
			else chk_val(24'(kind), 24'(exp_q.pop_front()));
		end
	end

	// A hang counts as a mismatch; the bound is about two and a half times the expected run.
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end

	// ==========================================================
	// Tests.
	initial begin
		{clk, rst, write_enable_latch, rprot, aprot, pbusy} = 6'b010000;
		a = 24'($urandom(47));
		idle(8);
		rst = 1'b0;
		chk_val(24'(obs), 24'h0);
		chk_val(24'(kind), 24'(SFE_OP_NONE));
		for (int k = 0; k < 5; k++) begin
			a = 24'($urandom);
			set_in(1'b1, 1'b0, 1'b0, 1'b0);
			exp_q.push_back(KINDS[k]);
			if (k < 3) host.send_cmd({OPS[k], a});
			else host.send_op(OPS[k]);
			wait_for(0, 1'b1, 40);
			chk_bit(busy, 1'b1);
			if (k < 3) chk_val(addr, (a >> LSBS[k]) << LSBS[k]);
			c0 = clears;
			idle(TIMES[k] - 80);
			chk_bit(busy, 1'b1);
			wait_for(0, 1'b0, 200);
			idle(4);
			chk_bit(busy, 1'b0);
			chk_val(24'(clears - c0), 24'h1);
			chk_val(24'(exp_q.size()), 24'h0);
		end
		$display("Test erase kinds done");
		set_in(1'b0, 1'b0, 1'b0, 1'b0);
		host.send_cmd({OP_SECTOR_ERASE, a});
		set_in(1'b1, 1'b1, 1'b0, 1'b0);
		host.send_cmd({OP_BLOCK32_ERASE, a});
		set_in(1'b1, 1'b0, 1'b1, 1'b0);
		host.send_op(OP_CHIP_ERASE_A);
		set_in(1'b1, 1'b0, 1'b0, 1'b0);
		host.frame({OP_BLOCK64_ERASE, a}, 31);
		host.frame({OP_CHIP_ERASE_B, a}, 9);
		idle(40);
		chk_bit(busy, 1'b0);
		$display("Test refusals done");
		exp_q.push_back(SFE_OP_SECTOR);
		host.send_cmd({OP_SECTOR_ERASE, a});
		host.send_op(OP_CHIP_ERASE_A);
		host.send_op(OP_POWER_DOWN);
		host.send_op(OP_SUSPEND);
		wait_for(1, 1'b1, 10);
		chk_bit(susp, 1'b1);
		wait_for(0, 1'b0, T_SUS + 10);
		chk_bit(busy, 1'b0);
		chk_bit(psus, 1'b0);
		c0 = refuses;
		host.send_cmd({OP_BLOCK32_ERASE, a});
		host.send_cmd({OP_SECREG_ERASE, a});
		host.send_op(OP_WRITE_STATUS);
		host.send_op(OP_SUSPEND);
		idle(10);
		chk_val(24'(refuses - c0), 24'h3);
		chk_bit(busy, 1'b0);
		host.send_op(OP_RESUME);
		wait_for(1, 1'b0, 10);
		chk_bit(susp, 1'b0);
		wait_for(0, 1'b1, 50);
		chk_bit(busy, 1'b1);
		c0 = clears;
		wait_for(0, 1'b0, TIMES[0] + 100);
		idle(4);
		chk_val(24'(clears - c0), 24'h1);
		chk_bit(pd, 1'b0);
		idle(T_SUS);
		$display("Test erase suspend done");
		exp_q.push_back(SFE_OP_CHIP);
		host.send_op(OP_CHIP_ERASE_B);
		host.send_op(OP_SUSPEND);
		idle(10);
		chk_bit(susp, 1'b0);
		chk_bit(busy, 1'b1);
		wait_for(0, 1'b0, TIMES[3] + 100);
		idle(4);
		$display("Test chip suspend done");
		set_in(1'b1, 1'b0, 1'b0, 1'b1);
		host.send_op(OP_SUSPEND);
		wait_for(1, 1'b1, 10);
		chk_bit(psus, 1'b1);
		c0 = refuses;
		host.send_cmd({OP_PAGE_PROG, a});
		host.send_cmd({OP_QUAD_PROG, a});
		host.send_cmd({OP_SECREG_PROG, a});
		idle(10);
		chk_val(24'(refuses - c0), 24'h3);
		rst = 1'b1;
		idle(2);
		rst = 1'b0;
		pbusy = 1'b0;
		chk_bit(susp, 1'b0);
		host.send_op(OP_RESUME);
		idle(80);
		chk_val(24'(obs), 24'h0);
		$display("Test program suspend done");
		host.send_op(OP_POWER_DOWN);
		wait_for(2, 1'b1, PD_ENTRY_CYC + 20);
		chk_bit(pd, 1'b1);
		host.send_cmd({OP_SECTOR_ERASE, a});
		idle(10);
		chk_bit(busy, 1'b0);
		host.send_op(OP_RELEASE_PD);
		wait_for(2, 1'b0, RELEASE_CYC + 20);
		chk_bit(pd, 1'b0);
		idle(RELEASE_CYC);
		$display("Test power-down done");
		tally_and_finish();
	end
endmodule
